//--- inc/pldm_pkg.sv
package pldm_pkg;

  localparam int NUM_TS = 12;
  localparam int TS_STRIDE = 8;

  // register word indices; byte address is four times the index
  localparam logic [9:0] IDX_CONFIG = 10'h100;
  localparam logic [9:0] IDX_CONCAT_STATE_TS1 = 10'h108;
  localparam logic [9:0] IDX_CONCAT_IRQ_ENABLE_TS1 = 10'h109;
  localparam logic [9:0] IDX_CONCAT_EVENT_TS1 = 10'h10A;
  localparam logic [9:0] IDX_PATH_DEFECT_STATE_TS1 = 10'h10B;
  localparam logic [9:0] IDX_PATH_DEFECT_IRQ_ENABLE_TS1 = 10'h10C;
  localparam logic [9:0] IDX_PATH_DEFECT_EVENT_TS1 = 10'h10D;

  localparam logic [2:0] SUB_CONCAT_STATE = 3'(IDX_CONCAT_STATE_TS1 - IDX_CONCAT_STATE_TS1);
  localparam logic [2:0] SUB_CONCAT_EN = 3'(IDX_CONCAT_IRQ_ENABLE_TS1 - IDX_CONCAT_STATE_TS1);
  localparam logic [2:0] SUB_CONCAT_EVT = 3'(IDX_CONCAT_EVENT_TS1 - IDX_CONCAT_STATE_TS1);
  localparam logic [2:0] SUB_DEF_STATE = 3'(IDX_PATH_DEFECT_STATE_TS1 - IDX_CONCAT_STATE_TS1);
  localparam logic [2:0] SUB_DEF_EN = 3'(IDX_PATH_DEFECT_IRQ_ENABLE_TS1 - IDX_CONCAT_STATE_TS1);
  localparam logic [2:0] SUB_DEF_EVT = 3'(IDX_PATH_DEFECT_EVENT_TS1 - IDX_CONCAT_STATE_TS1);

  // field positions
  localparam int CONCAT_BIT = 5;
  localparam int ST_UNSTABLE = 1;
  localparam int ST_ERDI = 6;
  localparam int NUM_EVT = 10;
  localparam int CFG_ALGO2_BIT = 0;
  localparam int CFG_LBL5_BIT = 1;
  localparam int CFG_RDI10_BIT = 2;
  localparam int CFG_EXP_LSB = 8;

  // reset values
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [9:0] DEF_EN_RESET = 10'h000;
  localparam logic CONCAT_EN_RESET = 1'b0;

  // frame counts
  localparam logic [3:0] LBL_N_SHORT = 4'h3;
  localparam logic [3:0] LBL_N_LONG = 4'h5;
  localparam logic [3:0] RDI_N_SHORT = 4'h5;
  localparam logic [3:0] RDI_N_LONG = 4'hA;
  localparam logic [2:0] UNSTABLE_N = 3'h5;

  // label classes
  localparam logic [7:0] LBL_UNEQ = 8'h00;
  localparam logic [7:0] LBL_EQUIPPED = 8'h01;
  localparam logic [7:0] LBL_PDI_LO = 8'hE1;
  localparam logic [7:0] LBL_PDI_HI = 8'hFC;

  typedef struct packed {
    logic frame;
    logic [7:0] rx_label;
    logic accept;
    logic [7:0] acc_label;
    logic [2:0] g1_rdi;
    logic parity_err;
    logic far_err;
    logic concat_alarm_state;
  } pldm_ts_in_t;

  typedef struct packed {
    logic hit;
    logic glob;
    logic [3:0] ts;
    logic [2:0] sub;
  } pldm_dec_t;

endpackage

//--- hdl/pldm_monitor.sv
`timescale 1ns/1ps
module pldm_monitor
  import pldm_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pldm_pkg::pldm_ts_in_t [pldm_pkg::NUM_TS-1:0] ts_in,
  output logic irq
);
  import pldm_pkg::*;

  function automatic pldm_dec_t decode(input logic [11:0] a);
    logic [9:0] off;
    decode = '0;
    off = a[11:2] - IDX_CONCAT_STATE_TS1;
    if (a[1:0] == 2'h0)
    begin
      if (a[11:2] == IDX_CONFIG)
      begin
        decode.hit = 1'b1;
        decode.glob = 1'b1;
      end
      else if (off < 10'(TS_STRIDE * NUM_TS) && off[2:0] <= SUB_DEF_EVT)
      begin
        decode.hit = 1'b1;
        decode.ts = off[6:3];
        decode.sub = off[2:0];
      end
    end
  endfunction

  function automatic logic lbl_match(input logic [7:0] rx, input logic [7:0] exp);
    lbl_match = (rx == exp) || (exp == LBL_EQUIPPED && rx != LBL_UNEQ);
  endfunction

  function automatic logic lbl_pdi(input logic [7:0] l);
    lbl_pdi = (l >= LBL_PDI_LO) && (l <= LBL_PDI_HI);
  endfunction

  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic irq_reg;
  logic [15:0] config_reg;
  logic [31:0] rd_next;
  logic access;
  logic done;
  logic wr_done;
  logic rd_done;
  pldm_dec_t dec;
  logic algo2;
  logic [3:0] lbl_n;
  logic [3:0] rdi_n;
  logic [7:0] exp_lbl;
  logic irq_next;

  logic [6:1] state_a [NUM_TS];
  logic [NUM_EVT-1:0] evt_a [NUM_TS];
  logic [NUM_EVT-1:0] en_a [NUM_TS];
  logic concat_a [NUM_TS];
  logic cevt_a [NUM_TS];
  logic cen_a [NUM_TS];

  assign access = psel && penable && !pready_reg;
  assign done = psel && penable && pready_reg;
  assign wr_done = done && pwrite && dec.hit;
  assign rd_done = done && !pwrite && dec.hit;
  assign dec = decode(paddr);
  assign algo2 = config_reg[CFG_ALGO2_BIT];
  assign lbl_n = config_reg[CFG_LBL5_BIT] ? LBL_N_LONG : LBL_N_SHORT;
  assign rdi_n = config_reg[CFG_RDI10_BIT] ? RDI_N_LONG : RDI_N_SHORT;
  assign exp_lbl = config_reg[CFG_EXP_LSB +: 8];

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

  // read data mux
  always_comb
  begin
    rd_next = 32'h0000_0000;
    if (dec.glob)
      rd_next[15:0] = config_reg;
    else if (dec.hit)
    begin
      case (dec.sub)
        SUB_CONCAT_STATE: rd_next[CONCAT_BIT] = concat_a[dec.ts];
        SUB_CONCAT_EN: rd_next[CONCAT_BIT] = cen_a[dec.ts];
        SUB_CONCAT_EVT: rd_next[CONCAT_BIT] = cevt_a[dec.ts];
        SUB_DEF_STATE: rd_next[6:1] = state_a[dec.ts];
        SUB_DEF_EN: rd_next[NUM_EVT-1:0] = en_a[dec.ts];
        SUB_DEF_EVT: rd_next[NUM_EVT-1:0] = evt_a[dec.ts];
        default: rd_next = 32'h0000_0000;
      endcase
    end
  end

  // apb: one wait state, answer on the second access edge
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= access;
      pslverr_reg <= access && !dec.hit;
      if (access && !pwrite)
        prdata_reg <= rd_next;
      else if (done)
        prdata_reg <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      config_reg <= CONFIG_RESET;
    else if (wr_done && dec.glob)
      config_reg <= pwdata[15:0];
  end

  always_comb
  begin
    irq_next = 1'b0;
    for (int i = 0; i < NUM_TS; i++)
      irq_next = irq_next || |(evt_a[i] & en_a[i]) || (cevt_a[i] && cen_a[i]);
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      irq_reg <= 1'b0;
    else
      irq_reg <= irq_next;
  end

  for (genvar i = 0; i < NUM_TS; i++)
  begin : g_ts
    pldm_ts_in_t t;
    logic sel;
    logic [7:0] last_lbl;
    logic [2:0] same_cnt;
    logic [2:0] same_nxt;
    logic persist;
    logic [2:0] diff_cnt;
    logic unstable_reg;
    logic filt_reg [4];
    logic [3:0] cond;
    logic [3:0] fcnt [4];
    logic [2:0] last_pat;
    logic [3:0] pat_cnt;
    logic [3:0] pat_nxt;
    logic [2:0] erdi_pat;
    logic erdi_reg;
    logic erdi_chg;
    logic [6:1] cur;
    logic [NUM_EVT-1:0] set;
    logic [NUM_EVT-1:0] clr;
    logic cclr;

    assign t = ts_in[i];
    assign sel = (dec.ts == 4'(i)) && !dec.glob;

    // label persistence: count of identical consecutive labels
    assign same_nxt = (t.rx_label != last_lbl) ? 3'h1 : (same_cnt == 3'h7) ? 3'h7 : same_cnt + 3'h1;
    assign persist = t.frame && (same_nxt == lbl_n[2:0]);

    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        last_lbl <= 8'h00;
        same_cnt <= 3'h0;
      end
      else if (t.frame)
      begin
        last_lbl <= t.rx_label;
        same_cnt <= same_nxt;
      end
    end

    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        diff_cnt <= 3'h0;
        unstable_reg <= 1'b0;
      end
      else if (persist)
      begin
        diff_cnt <= 3'h0;
        unstable_reg <= 1'b0;
      end
      else if (t.frame && t.rx_label != t.acc_label && diff_cnt != UNSTABLE_N)
      begin
        diff_cnt <= diff_cnt + 3'h1;
        if (diff_cnt + 3'h1 == UNSTABLE_N)
          unstable_reg <= 1'b1;
      end
    end

    // frame filters: mismatch, unequipped, payload defect, remote defect
    assign cond[0] = !lbl_match(t.rx_label, exp_lbl);
    assign cond[1] = (t.rx_label == LBL_UNEQ);
    assign cond[2] = lbl_pdi(t.rx_label);
    assign cond[3] = t.g1_rdi[2];

    for (genvar j = 0; j < 4; j++)
    begin : g_filt
      logic [3:0] n;
      assign n = (j == 3) ? rdi_n : lbl_n;
      always_ff @(posedge clock)
      begin
        if (reset)
        begin
          fcnt[j] <= 4'h0;
          filt_reg[j] <= 1'b0;
        end
        else if (t.frame)
        begin
          if (cond[j] == filt_reg[j])
            fcnt[j] <= 4'h0;
          else if (fcnt[j] + 4'h1 == n)
          begin
            fcnt[j] <= 4'h0;
            filt_reg[j] <= cond[j];
          end
          else
            fcnt[j] <= fcnt[j] + 4'h1;
        end
      end
    end

    // enhanced remote defect: accept a pattern after n identical frames
    assign pat_nxt = (t.g1_rdi != last_pat) ? 4'h1 : (pat_cnt == 4'hF) ? 4'hF : pat_cnt + 4'h1;
    assign erdi_chg = t.frame && pat_nxt == rdi_n && t.g1_rdi != erdi_pat;

    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        last_pat <= 3'h0;
        pat_cnt <= 4'h0;
        erdi_pat <= 3'h0;
        erdi_reg <= 1'b0;
      end
      else if (t.frame)
      begin
        last_pat <= t.g1_rdi;
        pat_cnt <= pat_nxt;
        if (pat_nxt == rdi_n)
        begin
          erdi_pat <= t.g1_rdi;
          erdi_reg <= t.g1_rdi[2] || (t.g1_rdi == 3'h2);
        end
      end
    end

    always_comb
    begin
      cur[ST_UNSTABLE] = algo2 && unstable_reg;
      cur[2] = algo2 ? !lbl_match(t.acc_label, exp_lbl) : filt_reg[0];
      cur[3] = filt_reg[1];
      cur[4] = algo2 ? lbl_pdi(t.acc_label) : filt_reg[2];
      cur[5] = filt_reg[3];
      cur[ST_ERDI] = erdi_reg;
    end

    assign set = {t.far_err, t.parity_err, erdi_chg, cur ^ state_a[i], t.accept};
    assign clr = (rd_done && sel && dec.sub == SUB_DEF_EVT) ? prdata_reg[NUM_EVT-1:0] :
                 (wr_done && sel && dec.sub == SUB_DEF_EVT) ? pwdata[NUM_EVT-1:0] : '0;
    assign cclr = (rd_done && sel && dec.sub == SUB_CONCAT_EVT && prdata_reg[CONCAT_BIT]) ||
                  (wr_done && sel && dec.sub == SUB_CONCAT_EVT && pwdata[CONCAT_BIT]);

    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        state_a[i] <= 6'h00;
        evt_a[i] <= '0;
      end
      else
      begin
        state_a[i] <= cur;
        evt_a[i] <= (evt_a[i] & ~clr) | set;
      end
    end

    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        concat_a[i] <= 1'b0;
        cevt_a[i] <= 1'b0;
      end
      else
      begin
        concat_a[i] <= t.concat_alarm_state;
        cevt_a[i] <= (cevt_a[i] && !cclr) || (concat_a[i] != t.concat_alarm_state);
      end
    end

    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        en_a[i] <= DEF_EN_RESET;
        cen_a[i] <= CONCAT_EN_RESET;
      end
      else if (wr_done && sel)
      begin
        if (dec.sub == SUB_DEF_EN)
          en_a[i] <= pwdata[NUM_EVT-1:0];
        if (dec.sub == SUB_CONCAT_EN)
          cen_a[i] <= pwdata[CONCAT_BIT];
      end
    end
  end

endmodule // pldm_monitor

//--- test/pldm_monitor_asserts.sv
`timescale 1ns/1ps
module pldm_monitor_asserts
  import pldm_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire pldm_pkg::pldm_ts_in_t [pldm_pkg::NUM_TS-1:0] ts_in,
  input wire logic irq
);
  import pldm_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  // first access cycle, answer due next cycle
  wire acc = psel && penable && !pready;
  one_wait_a: assert property (acc |=> pready)
    else $error("no ready one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  misalign_err_a: assert property (acc && paddr[1:0] != 2'b00 |=> pslverr)
    else $error("misaligned access not refused");
  data_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read answer");
  upper_zero_a: assert property (prdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  irq_sticky_a: assert property ($fell(irq) |-> $past(pready) || $past(pready, 2))
    else $error("interrupt dropped without access");
  reset_quiet_a: assert property (disable iff (1'b0) reset |=> !irq && !pready)
    else $error("outputs active after reset");
  // read answer of timeslot 0 concat state shows the input two edges back
  wire ts0_rd = pready && !pwrite && paddr == 12'h420;
  wire ts0_alarm = ts_in[0].concat_alarm_state;
  concat_read_a: assert property (ts0_rd |-> prdata[CONCAT_BIT] == $past(ts0_alarm, 2))
    else $error("concat state read differs from input");
  irq_seen_c: cover property ($rose(irq));
  err_seen_c: cover property (pslverr);
  read_seen_c: cover property (pready && !pwrite && prdata != 32'h0);
endmodule // pldm_monitor_asserts
bind pldm_monitor pldm_monitor_asserts u_chk (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ts_in(ts_in), .irq(irq));

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pldm_pkg::*;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} pldm_row_t;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  pldm_ts_in_t [NUM_TS-1:0] ts_in = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, er;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  pldm_row_t rows [10];
  always #4 clock = ~clock;
  pldm_monitor u_dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ts_in(ts_in), .irq(irq));
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      final_report();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] q);
    apb(1'b0, a, 32'h0);
    chk(rd, q);
  endtask
  task frames(input int k, input logic [7:0] l, input logic [2:0] g, input int n);
    repeat (n)
    begin
      @(posedge clock);
      ts_in[k].frame <= 1'b1;
      ts_in[k].rx_label <= l;
      ts_in[k].g1_rdi <= g;
      @(posedge clock);
      ts_in[k].frame <= 1'b0;
    end
  endtask
  initial
  begin
    rows = '{'{1'h0, 12'h400, 32'h0, 32'h0, 1'h0}, '{1'h1, 12'h490, 32'hFFFFFFFF, 32'h0, 1'h0},
      '{1'h0, 12'h490, 32'h0, 32'h3FF, 1'h0}, '{1'h0, 12'h58C, 32'h0, 32'h0, 1'h0},
      '{1'h1, 12'h42C, 32'hFFFF, 32'h0, 1'h0}, '{1'h0, 12'h42C, 32'h0, 32'h0, 1'h0},
      '{1'h0, 12'h438, 32'h0, 32'h0, 1'h1}, '{1'h1, 12'h401, 32'h0, 32'h0, 1'h1},
      '{1'h0, 12'h5C0, 32'h0, 32'h0, 1'h1}, '{1'h0, 12'h424, 32'h0, 32'h0, 1'h0}};
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(rd, rows[i].q);
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
    $display("register table done");
    ts_in[0].concat_alarm_state <= 1'b1;
    rdc(12'h420, 32'h20);
    rdc(12'h428, 32'h20);
    chk({31'h0, irq}, 32'h0);
    rdc(12'h428, 32'h0);
    ts_in[0].concat_alarm_state <= 1'b0;
    apb(1'b1, 12'h424, 32'h20);
    repeat (4) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    rdc(12'h428, 32'h20);
    repeat (3) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    $display("concat alarm done");
    ts_in[5].accept <= 1'b1;
    ts_in[5].parity_err <= 1'b1;
    ts_in[5].far_err <= 1'b1;
    @(posedge clock);
    ts_in[5].accept <= 1'b0;
    ts_in[5].parity_err <= 1'b0;
    ts_in[5].far_err <= 1'b0;
    repeat (3) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h4D0, 32'h100);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    rdc(12'h4D4, 32'h301);
    repeat (3) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    $display("events done");
    for (int i = 1; i <= 3; i++)
    begin
      frames(1, 8'h00, 3'b000, 1);
      rdc(12'h44C, i == 3 ? 32'h8 : 32'h0);
    end
    frames(1, 8'hE1, 3'b000, 2);
    rdc(12'h44C, 32'h8);
    frames(1, 8'hE1, 3'b000, 1);
    rdc(12'h44C, 32'h14);
    frames(2, 8'h00, 3'b100, 4);
    rdc(12'h46C, 32'h8);
    frames(2, 8'h00, 3'b100, 1);
    rdc(12'h46C, 32'h68);
    // long counts, expected label meaning any equipped label
    apb(1'b1, 12'h400, 32'h0106);
    frames(6, 8'h00, 3'b010, 4);
    rdc(12'h4EC, 32'h0);
    frames(6, 8'h00, 3'b010, 1);
    rdc(12'h4EC, 32'hC);
    frames(6, 8'h13, 3'b010, 5);
    rdc(12'h4EC, 32'h40);
    $display("filters done");
    apb(1'b1, 12'h400, 32'h1);
    frames(4, 8'h11, 3'b000, 1);
    frames(4, 8'h22, 3'b000, 1);
    frames(4, 8'h11, 3'b000, 1);
    frames(4, 8'h22, 3'b000, 1);
    rdc(12'h4AC, 32'h0);
    frames(4, 8'h11, 3'b000, 1);
    rdc(12'h4AC, 32'h2);
    frames(4, 8'h11, 3'b000, 2);
    rdc(12'h4AC, 32'h0);
    ts_in[4].acc_label <= 8'hE5;
    repeat (3) @(posedge clock);
    rdc(12'h4AC, 32'h14);
    $display("second algorithm done");
    // mid-run reset with an enabled event pending
    apb(1'b1, 12'h4B0, 32'h3FF);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    reset <= 1'b1;
    repeat (4) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, pready}, 32'h0);
    reset <= 1'b0;
    rdc(12'h4B0, 32'h0);
    rdc(12'h400, 32'h0);
    rdc(12'h4B4, 32'h0);
    $display("reset done");
    final_report();
  end
endmodule // testbench
